// ### rtl/sleep_mode_pkg.sv
// shared constants for the sleep mode setpoint selector
package sleep_mode_pkg;
  localparam int SP_W = 12;
  localparam logic [31:0] REG_CTRL_OFS   = 32'h0000_0000;
  localparam logic [31:0] REG_STATUS_OFS = 32'h0000_0004;
  localparam logic [31:0] REG_TARGET_OFS = 32'h0000_0008;
  localparam logic [31:0] REG_DEEP_OFS   = 32'h0000_000C;
  localparam logic [31:0] REG_DEEPER_OFS = 32'h0000_0010;
  localparam int CTRL_DE_EN_BIT = 0;
  localparam logic [31:0] CTRL_RST_VAL = 32'h0000_0001;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_DIODE_BIT = 4;
  localparam int ST_SINGLE_BIT = 5;
  localparam int DROOP_SHIFT = 4;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    MODE_ACTIVE = 3'h1,
    MODE_DEEP   = 3'h2,
    MODE_DEEPER = 3'h4
  } mode_t;
endpackage

// ### rtl/mode_decode.sv
// combinational decode of the two sleep control pins into a mode
`timescale 1ns/100ps
module mode_decode (
  input  wire logic                 stop_clock_sleep_in_n,
  input  wire logic                 deeper_sleep_in,
  output sleep_mode_pkg::mode_t     mode
);
  always_comb begin
    if (deeper_sleep_in) begin
      mode = sleep_mode_pkg::MODE_DEEPER;
    end else if (stop_clock_sleep_in_n) begin
      mode = sleep_mode_pkg::MODE_ACTIVE;
    end else begin
      mode = sleep_mode_pkg::MODE_DEEP;
    end
  end
endmodule

// ### rtl/sleep_mode_setpoint_select.sv
// regulator mode selection, setpoint mux, diode emulation and phase control
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
// Functional notes
// - stop-clock high, deeper low after reset gives Active, target from ident code.
// - in Active the target follows every ident code change.
// - Active target is converter output minus load droop.
// - both inputs low gives Deep Sleep, target from deep-sleep setpoint.
// - Deep Sleep runs the power stage in diode emulation.
// - stop-clock low, deeper high gives Deeper Sleep, deeper setpoint.
// - phase select tied to stop-clock gives single phase in Deep Sleep, and in Deeper Sleep only while stop-clock is low.
// - phase select from inverted deeper request gives single phase in Deeper only.
// - deep setpoint is a fixed fraction of the converter output.
module sleep_mode_setpoint_select #(
  parameter int SP_W = sleep_mode_pkg::SP_W
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 stop_clock_sleep_in_n,
  input  wire logic                 deeper_sleep_in,
  input  wire logic                 phase_count_select,
  input  wire logic [SP_W-1:0]      voltage_ident_dac,
  input  wire logic [SP_W-1:0]      deep_sleep_setpoint,
  input  wire logic [SP_W-1:0]      deeper_sleep_setpoint,
  input  wire logic [SP_W-1:0]      droop_sense,
  output logic [SP_W-1:0]           target_setpoint,
  output logic [2:0]                mode_out,
  output logic                      diode_emulation,
  output logic                      single_phase,
  input  wire logic [31:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [31:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);
  sleep_mode_pkg::mode_t mode_c;
  logic [SP_W-1:0]       droop_amt;
  logic [SP_W-1:0]       sel_c;
  logic                  diode_en_r;
  logic                  aw_got_r;
  logic                  w_got_r;
  logic [31:0]           awaddr_r;
  logic [31:0]           wdata_r;
  logic [3:0]            wstrb_r;

  mode_decode u_dec (
    .stop_clock_sleep_in_n (stop_clock_sleep_in_n),
    .deeper_sleep_in       (deeper_sleep_in),
    .mode                  (mode_c)
  );

  // droop is a scaled copy of sensed load; the target subtraction below saturates at zero
  assign droop_amt = droop_sense >> sleep_mode_pkg::DROOP_SHIFT;

  always_comb begin
    case (mode_c)
      sleep_mode_pkg::MODE_ACTIVE: sel_c = voltage_ident_dac;
      sleep_mode_pkg::MODE_DEEP:   sel_c = deep_sleep_setpoint;
      default:                     sel_c = deeper_sleep_setpoint;
    endcase
  end

  // registered outputs; the pins are taken as synchronous, so one flop stage only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      target_setpoint <= '0;
      mode_out        <= sleep_mode_pkg::MODE_ACTIVE;
      diode_emulation <= 1'b0;
      single_phase    <= 1'b0;
    end else begin
      target_setpoint <= (sel_c > droop_amt) ? sel_c - droop_amt : '0;
      mode_out        <= mode_c;
      diode_emulation <= diode_en_r && (mode_c != sleep_mode_pkg::MODE_ACTIVE);
      // phase select is low whenever the wiring asks for one phase
      single_phase    <= !phase_count_select && (mode_c != sleep_mode_pkg::MODE_ACTIVE);
    end
  end

  // write channel: address and data accepted in either order
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_r && !s_axi_bvalid;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= '0;
      wdata_r  <= '0;
      wstrb_r  <= '0;
    end else if (aw_got_r && w_got_r) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      diode_en_r   <= sleep_mode_pkg::CTRL_RST_VAL[sleep_mode_pkg::CTRL_DE_EN_BIT];
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= sleep_mode_pkg::RESP_OKAY;
    end else if (aw_got_r && w_got_r) begin
      s_axi_bvalid <= 1'b1;
      if ({awaddr_r[31:2], 2'b00} == sleep_mode_pkg::REG_CTRL_OFS) begin
        s_axi_bresp <= sleep_mode_pkg::RESP_OKAY;
        if (wstrb_r[0]) begin
          diode_en_r <= wdata_r[sleep_mode_pkg::CTRL_DE_EN_BIT];
        end
      end else if ({awaddr_r[31:2], 2'b00} <= sleep_mode_pkg::REG_DEEPER_OFS) begin
        s_axi_bresp <= sleep_mode_pkg::RESP_OKAY;
      end else begin
        s_axi_bresp <= sleep_mode_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= sleep_mode_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= sleep_mode_pkg::RESP_OKAY;
      s_axi_rdata  <= '0;
      if ({s_axi_araddr[31:2], 2'b00} == sleep_mode_pkg::REG_CTRL_OFS) begin
        s_axi_rdata[sleep_mode_pkg::CTRL_DE_EN_BIT] <= diode_en_r;
      end else if ({s_axi_araddr[31:2], 2'b00} == sleep_mode_pkg::REG_STATUS_OFS) begin
        s_axi_rdata[sleep_mode_pkg::ST_MODE_LSB +: 3] <= mode_out;
        s_axi_rdata[sleep_mode_pkg::ST_DIODE_BIT]     <= diode_emulation;
        s_axi_rdata[sleep_mode_pkg::ST_SINGLE_BIT]    <= single_phase;
      end else if ({s_axi_araddr[31:2], 2'b00} == sleep_mode_pkg::REG_TARGET_OFS) begin
        s_axi_rdata[SP_W-1:0] <= target_setpoint;
      end else if ({s_axi_araddr[31:2], 2'b00} == sleep_mode_pkg::REG_DEEP_OFS) begin
        s_axi_rdata[SP_W-1:0] <= deep_sleep_setpoint;
      end else if ({s_axi_araddr[31:2], 2'b00} == sleep_mode_pkg::REG_DEEPER_OFS) begin
        s_axi_rdata[SP_W-1:0] <= deeper_sleep_setpoint;
      end else begin
        s_axi_rresp <= sleep_mode_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // assertions
  a_active_select: assert property (@(posedge core_clk) disable iff (!rst_n)
    (stop_clock_sleep_in_n && !deeper_sleep_in) |=> mode_out == sleep_mode_pkg::MODE_ACTIVE)
    else $error("active mode not selected");
  a_ident_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
    (mode_c == sleep_mode_pkg::MODE_ACTIVE && droop_sense == '0)
      |=> target_setpoint == $past(voltage_ident_dac))
    else $error("target does not follow ident code");
  a_droop_cut: assert property (@(posedge core_clk) disable iff (!rst_n)
    (mode_c == sleep_mode_pkg::MODE_ACTIVE) |=> target_setpoint <= $past(voltage_ident_dac))
    else $error("droop raised the target");
  a_deep_select: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!stop_clock_sleep_in_n && !deeper_sleep_in && droop_sense == '0)
      |=> mode_out == sleep_mode_pkg::MODE_DEEP && target_setpoint == $past(deep_sleep_setpoint))
    else $error("deep sleep setpoint not selected");
  a_diode_deep: assert property (@(posedge core_clk) disable iff (!rst_n)
    (mode_c == sleep_mode_pkg::MODE_DEEP && diode_en_r) |=> diode_emulation)
    else $error("diode emulation missing in deep sleep");
  a_deeper_select: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!stop_clock_sleep_in_n && deeper_sleep_in && droop_sense == '0)
      |=> mode_out == sleep_mode_pkg::MODE_DEEPER && target_setpoint == $past(deeper_sleep_setpoint))
    else $error("deeper sleep setpoint not selected");
  a_single_tied: assert property (@(posedge core_clk) disable iff (!rst_n)
    (phase_count_select == stop_clock_sleep_in_n && !stop_clock_sleep_in_n) |=> single_phase)
    else $error("single phase missing in sleep");
  a_single_deeper: assert property (@(posedge core_clk) disable iff (!rst_n)
    (phase_count_select == !deeper_sleep_in) |=> single_phase == $past(deeper_sleep_in))
    else $error("single phase wrong with inverted request");
  a_both_high: assert property (@(posedge core_clk) disable iff (!rst_n)
    (stop_clock_sleep_in_n && deeper_sleep_in) |=> mode_out == sleep_mode_pkg::MODE_DEEPER)
    else $error("both high not deeper sleep");
endmodule

// ### sim/chipset_sleep_model.sv
// chipset side model: sleep pins plus board strap of phase select and deep level
`timescale 1ns/100ps
module chipset_sleep_model (
  input  wire logic        system_stop_cpu_n,
  input  wire logic        system_deeper_sleep_req,
  input  wire logic        pcs_inv_deeper,
  input  wire logic [11:0] voltage_ident_dac,
  output logic             stop_clock_sleep_in_n,
  output logic             deeper_sleep_in,
  output logic             phase_count_select,
  output logic [11:0]      deep_sleep_setpoint
);
  assign stop_clock_sleep_in_n = system_stop_cpu_n;
  assign deeper_sleep_in       = system_deeper_sleep_req;
  // strap choice: tied to the stop pin, or the inverted deeper request
  assign phase_count_select = pcs_inv_deeper ? ~system_deeper_sleep_req : system_stop_cpu_n;
  // divider off the converter output; 253/256 sits close to the nominal fraction
  assign deep_sleep_setpoint = 12'(({8'h00, voltage_ident_dac} * 20'h000FD) >> 8);
endmodule

// ### sim/tb_top.sv
// self-checking bench for the sleep mode setpoint selector
`timescale 1ns/100ps
module tb_top;
  logic        core_clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        stp_n = 1'h1, drq = 1'h0, inv = 1'h0, act, ta, tw, tr, td;
  logic [11:0] voltage_ident_dac = 12'h800, deeper_sleep_setpoint = 12'h600, droop_sense = 12'h050;
  logic        stop_clock_sleep_in_n, deeper_sleep_in, phase_count_select, diode_emulation, single_phase;
  logic [11:0] deep_sleep_setpoint, target_setpoint;
  logic [11:0] vs[3] = '{12'h123, 12'hFFF, 12'h004};
  logic [2:0]  mode_out;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, rd;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  int          n_mismatch = 0, checks_done = 0, cyc = 0;
  always #50 core_clk = ~core_clk;
  chipset_sleep_model u_chipset_sleep_model (.system_stop_cpu_n(stp_n), .system_deeper_sleep_req(drq),
    .pcs_inv_deeper(inv), .voltage_ident_dac, .stop_clock_sleep_in_n, .deeper_sleep_in, .phase_count_select,
    .deep_sleep_setpoint);
  sleep_mode_setpoint_select u_sleep_mode_setpoint_select (.core_clk, .rst_n, .stop_clock_sleep_in_n,
    .deeper_sleep_in, .phase_count_select, .voltage_ident_dac, .deep_sleep_setpoint, .deeper_sleep_setpoint,
    .droop_sense, .target_setpoint, .mode_out, .diode_emulation, .single_phase, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  task automatic final_report();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // the sequence needs under a hundred cycles, so this only trips on a hang
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL time %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [11:0] tgt(input logic [11:0] s);
    logic [11:0] d;
    d = droop_sense >> sleep_mode_pkg::DROOP_SHIFT;
    return (s > d) ? s - d : 12'h000;
  endfunction
  function automatic logic [11:0] dp(input logic [11:0] v);
    return 12'(({8'h00, v} * 20'h000FD) >> 8);
  endfunction
  // one bus transfer; each handshake is judged at the rising edge that completes it
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    td = 1'h0;
    while (!td) begin
      @(posedge core_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_arvalid && s_axi_arready;
      td = (s_axi_bready && s_axi_bvalid) || (s_axi_rready && s_axi_rvalid);
      rsp = w ? s_axi_bresp : s_axi_rresp;
      rd = s_axi_rdata;
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tr) s_axi_arvalid <= 1'h0;
      if (td) s_axi_bready <= 1'h0;
      if (td) s_axi_rready <= 1'h0;
    end
  endtask
  task automatic drive(input logic s, input logic d, input logic p, input logic [11:0] v);
    @(posedge core_clk);
    stp_n <= s;
    drq <= d;
    inv <= p;
    voltage_ident_dac <= v;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'h1;
    xfer(1'h0, sleep_mode_pkg::REG_CTRL_OFS, 32'h0);
    chk(rd, sleep_mode_pkg::CTRL_RST_VAL);
    for (int i = 0; i < 8; i++) begin
      drive(i[1], i[0], i[2], 12'h800);
      act = i[1] && !i[0];
      chk(mode_out, act ? sleep_mode_pkg::MODE_ACTIVE : (i[0] ? sleep_mode_pkg::MODE_DEEPER : sleep_mode_pkg::MODE_DEEP));
      chk(target_setpoint, tgt(act ? 12'h800 : (i[0] ? deeper_sleep_setpoint : dp(12'h800))));
      chk(diode_emulation, !act);
      chk(single_phase, !act && !(i[2] ? !i[0] : i[1]));
    end
    xfer(1'h0, sleep_mode_pkg::REG_STATUS_OFS, 32'h0);
    chk(rd[5:0], 6'h34);
    foreach (vs[k]) begin
      drive(1'h1, 1'h0, 1'h0, vs[k]);
      chk(target_setpoint, tgt(vs[k]));
    end
    drive(1'h0, 1'h0, 1'h0, 12'hA00);
    chk(target_setpoint, tgt(dp(12'hA00)));
    xfer(1'h1, sleep_mode_pkg::REG_CTRL_OFS, 32'h0);
    chk(rsp, sleep_mode_pkg::RESP_OKAY);
    drive(1'h0, 1'h0, 1'h0, 12'hA00);
    chk(diode_emulation, 1'h0);
    xfer(1'h1, sleep_mode_pkg::REG_STATUS_OFS, 32'hFFFFFFFF);
    chk(rsp, sleep_mode_pkg::RESP_OKAY);
    xfer(1'h0, sleep_mode_pkg::REG_CTRL_OFS, 32'h0);
    chk(rd, 32'h0);
    xfer(1'h0, 32'h00000020, 32'h0);
    chk(rsp, sleep_mode_pkg::RESP_SLVERR);
    xfer(1'h1, 32'h00000024, 32'h1);
    chk(rsp, sleep_mode_pkg::RESP_SLVERR);
    // no load: the exact-level assertions only arm while droop is zero
    droop_sense <= 12'h000;
    drive(1'h1, 1'h0, 1'h0, 12'h3C0);
    chk(target_setpoint, 12'h3C0);
    drive(1'h0, 1'h0, 1'h0, 12'h3C0);
    chk(target_setpoint, dp(12'h3C0));
    drive(1'h0, 1'h1, 1'h0, 12'h3C0);
    chk(target_setpoint, deeper_sleep_setpoint);
    final_report();
  end
endmodule
